/* mps_power_ctrl.sv */
/*
  Power-on, orderly and emergency switch-off, and sleep/wake sequencing of the modem.
  Assumes pins arrive asynchronously; UART byte strobe, command strobes, task-idle and
  USB enumeration flags come from logic on mclk.
*/
`include "mps_defines.svh"
`default_nettype none

// Summary of operation
// RQ1 - host holds power request low 25 ms; shorter pulses are ignored.
// RQ2 - after the trigger is taken, the power request pin is ignored.
// RQ3 - io rail indicator rises within about 25 ms of the request.
// RQ4 - command interface becomes ready 7 s after the power request.
// RQ5 - cts falls high to low when commands may be sent.
// RQ6 - usb traffic is enabled only after enumeration completes.
// RQ7 - emergency pulse is 20 ms low with power request high.
// RQ8 - valid emergency pulse shuts down at once and clears cpu state.
// RQ9 - emergency path is for a frozen device only.
// RQ10 - policy 0: awake while dtr low, sleep after delay once dtr high.
// RQ11 - policy 1: sleep when no tasks remain, wake on 0x00 character.
// RQ12 - policy 2: never sleep.
// RQ13 - host picks policy 1 when usb is in use.
// RQ14 - poweroff command gives an orderly switch-off.
// RQ15 - host times its pulses with a counter, rounding up.
module mps_power_ctrl
    import mps_pkg::*;
#(
    parameter int unsigned PWR_ON_CYC = `MPS_PWR_ON_CYC,
    parameter int unsigned BOOT_CYC = `MPS_BOOT_CYC,
    parameter int unsigned EMG_CYC = `MPS_EMG_CYC,
    parameter int unsigned SLEEP_CYC = `MPS_SLEEP_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_on_request_n,
    input wire logic emergency_reset_n,
    input wire logic dtr_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tasks_idle,
    input wire logic usb_enum_done,
    input wire logic orderly_poweroff_command,
    input wire logic sleep_policy_command,
    input wire logic [1:0] sleep_policy_value,
    output logic io_rail_indicator,
    output logic cts_n,
    output logic usb_comm_en,
    output logic sleep_active,
    output logic cpu_hold_reset,
    output logic mem_clear
);

    localparam int SHUT_INT = `MPS_SHUT_CYC;
    localparam logic [31:0] PWR_ON_LAST = 32'(PWR_ON_CYC - 1);
    localparam logic [31:0] BOOT_LAST = 32'(BOOT_CYC - 1);
    localparam logic [31:0] EMG_LAST = 32'(EMG_CYC - 1);
    localparam logic [31:0] SLEEP_LAST = 32'(SLEEP_CYC - 1);
    localparam logic [31:0] SHUT_LAST = 32'(SHUT_INT - 1);

    logic [2:0] pins_sync;
    mps_pin_sync #(
        .WIDTH(3),
        .IDLE(`MPS_PIN_IDLE)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_in({dtr_n, emergency_reset_n, power_on_request_n}),
        .pin_out(pins_sync)
    );

    wire pwr_req_low = !pins_sync[0];
    wire emg_low = !pins_sync[1];
    wire dtr_low = !pins_sync[2];

    mps_state_type state_ff;
    mps_state_type nxt_state;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic [31:0] emg_cnt_ff;
    logic [31:0] idle_cnt_ff;
    logic [1:0] policy_ff;
    logic io_rail_ff;
    logic cts_n_ff;
    logic usb_en_ff;
    logic sleep_ff;
    logic hold_ff;
    logic mem_clear_ff;

    // emergency counts only while the power request is high; a low request spoils the pulse
    wire emg_armed = emg_low && !pwr_req_low; // [RQ7]
    wire emg_hit = emg_armed && (emg_cnt_ff == EMG_LAST); // [RQ8]
    wire arm_done = pwr_req_low && (cnt_ff == PWR_ON_LAST); // [RQ1]
    wire boot_done = (cnt_ff == BOOT_LAST); // [RQ4]
    wire shut_done = (cnt_ff == SHUT_LAST);
    wire wake_char = rx_valid && (rx_data == `MPS_WAKE_CHAR); // [RQ11]
    wire pol_dtr = (policy_ff == MPS_POL_DTR);
    wire pol_auto = (policy_ff == MPS_POL_AUTO);
    wire pol_never = (policy_ff == MPS_POL_NEVER);
    // the idle delay stands for "after a while"; policy 1 reuses it so short gaps do not sleep
    wire idle_cond = (pol_dtr && !dtr_low) || (pol_auto && tasks_idle);
    wire idle_done = idle_cond && (idle_cnt_ff == SLEEP_LAST);
    wire wake_cond = pol_never || (pol_dtr && dtr_low) || (pol_auto && wake_char);
    wire policy_ok = sleep_policy_command && (sleep_policy_value != 2'h3);
    wire [31:0] cnt_inc = cnt_ff + 32'h1;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_inc;
        case (state_ff)
            MPS_OFF:
            begin
                nxt_cnt = 32'h0;
                if (pwr_req_low)
                begin
                    nxt_state = MPS_ARM;
                end
            end
            MPS_ARM:
            begin
                if (!pwr_req_low)
                begin
                    nxt_state = MPS_OFF; // [RQ1]
                end
                else if (arm_done)
                begin
                    nxt_state = MPS_BOOT; // [RQ3]
                end
            end
            MPS_BOOT:
            begin
                // the sequencer no longer looks at the request pin; emg_armed still needs it high for an emergency pulse to count
                if (boot_done)
                begin
                    nxt_state = MPS_READY; // [RQ2] [RQ4]
                end
            end
            MPS_READY:
            begin
                nxt_cnt = 32'h0;
                if (orderly_poweroff_command)
                begin
                    nxt_state = MPS_SHUTDOWN; // [RQ14]
                end
                else if (idle_done)
                begin
                    nxt_state = MPS_SLEEP; // [RQ10] [RQ11]
                end
            end
            MPS_SLEEP:
            begin
                nxt_cnt = 32'h0;
                if (wake_cond)
                begin
                    nxt_state = MPS_READY; // [RQ10] [RQ11] [RQ12]
                end
            end
            MPS_SHUTDOWN:
            begin
                if (shut_done)
                begin
                    nxt_state = MPS_OFF; // [RQ14]
                end
            end
            default:
            begin
                nxt_state = MPS_OFF;
            end
        endcase
        if (emg_hit)
        begin
            nxt_state = MPS_OFF; // [RQ8]
            nxt_cnt = 32'h0;
        end
    end

    wire nxt_on = (nxt_state != MPS_OFF) && (nxt_state != MPS_ARM);
    wire nxt_ready = (nxt_state == MPS_READY);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= MPS_OFF;
            cnt_ff <= 32'h0;
            emg_cnt_ff <= 32'h0;
            idle_cnt_ff <= 32'h0;
            policy_ff <= `MPS_POLICY_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            emg_cnt_ff <= (emg_armed && !emg_hit) ? emg_cnt_ff + 32'h1 : 32'h0;
            idle_cnt_ff <= (state_ff == MPS_READY && idle_cond && !idle_done) ? idle_cnt_ff + 32'h1 : 32'h0;
            if (policy_ok)
            begin
                policy_ff <= sleep_policy_value;
            end
        end
    end

    // outputs follow the next state so they line up with the state register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_rail_ff <= 1'b0;
            cts_n_ff <= 1'b1;
            usb_en_ff <= 1'b0;
            sleep_ff <= 1'b0;
            hold_ff <= 1'b1;
            mem_clear_ff <= 1'b0;
        end
        else
        begin
            io_rail_ff <= nxt_on; // [RQ3]
            cts_n_ff <= !nxt_ready; // [RQ5]
            usb_en_ff <= nxt_ready && usb_enum_done; // [RQ6]
            sleep_ff <= (nxt_state == MPS_SLEEP);
            hold_ff <= !nxt_on; // [RQ8]
            mem_clear_ff <= emg_hit; // [RQ8]
        end
    end

    assign io_rail_indicator = io_rail_ff;
    assign cts_n = cts_n_ff;
    assign usb_comm_en = usb_en_ff;
    assign sleep_active = sleep_ff;
    assign cpu_hold_reset = hold_ff;
    assign mem_clear = mem_clear_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    arm_abort_a: assert property ((state_ff == MPS_ARM) && !pwr_req_low && !emg_hit |=> state_ff == MPS_OFF) // [RQ1]
        else $error("short power request was not discarded");
    rail_rise_a: assert property ((state_ff == MPS_ARM) && arm_done && !emg_hit |=> io_rail_indicator && cts_n) // [RQ3]
        else $error("io rail did not rise after valid trigger");
    boot_ready_a: assert property ((state_ff == MPS_BOOT) && boot_done && !emg_hit |=> !cts_n ##0 $past(cts_n)) // [RQ4]
        else $error("command interface not ready at end of boot");
    cts_state_a: assert property ($fell(cts_n) |-> $past(state_ff) == MPS_BOOT || $past(state_ff) == MPS_SLEEP) // [RQ5]
        else $error("cts fell outside boot or wake");
    usb_gate_a: assert property (usb_comm_en |-> $past(usb_enum_done) && state_ff == MPS_READY) // [RQ6]
        else $error("usb traffic before enumeration");
    emg_off_a: assert property (emg_hit |=> mem_clear && cpu_hold_reset && !io_rail_indicator ##1 !mem_clear) // [RQ8]
        else $error("emergency pulse did not shut down and clear");
    dtr_wake_a: assert property ((state_ff == MPS_SLEEP) && pol_dtr && dtr_low && !emg_hit |=> !sleep_active) // [RQ10]
        else $error("dtr low did not wake");
    char_wake_a: assert property ((state_ff == MPS_SLEEP) && pol_auto && wake_char && !emg_hit |=> !cts_n) // [RQ11]
        else $error("wake character did not wake");
    never_sleep_a: assert property (pol_never |=> !(state_ff == MPS_SLEEP)) // [RQ12]
        else $error("sleep entered under never-sleep policy");
    poweroff_a: assert property ((state_ff == MPS_READY) && orderly_poweroff_command && !emg_hit
        |=> (state_ff == MPS_SHUTDOWN) ##[1:SHUT_INT] !io_rail_indicator) // [RQ14]
        else $error("orderly poweroff did not complete");

    boot_seen_c: cover property ((state_ff == MPS_BOOT) ##1 (state_ff == MPS_READY));
    sleep_wake_c: cover property (sleep_active ##1 !sleep_active);
    emg_seen_c: cover property (mem_clear);
    shut_seen_c: cover property ((state_ff == MPS_SHUTDOWN) ##1 (state_ff == MPS_OFF));

endmodule

`default_nettype wire

/* mps_defines.svh */
/*
  Timing figures and reset values for the modem power and sleep controller.
  Assumes a single 125 MHz clock; times are kept in their own units and cycle
  counts are derived from them.
*/
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH

`define MPS_CLK_KHZ 125000
`define MPS_PWR_ON_MIN_MS 25
`define MPS_PWR_ON_CYC (`MPS_PWR_ON_MIN_MS * `MPS_CLK_KHZ)
`define MPS_BOOT_S 7
`define MPS_BOOT_CYC (`MPS_BOOT_S * `MPS_CLK_KHZ * 1000)
`define MPS_EMG_MIN_MS 20
`define MPS_EMG_CYC (`MPS_EMG_MIN_MS * `MPS_CLK_KHZ)
`define MPS_SLEEP_DLY_MS 100
`define MPS_SLEEP_CYC (`MPS_SLEEP_DLY_MS * `MPS_CLK_KHZ)
`define MPS_SHUT_US 8
`define MPS_SHUT_CYC (`MPS_SHUT_US * `MPS_CLK_KHZ / 1000)
`define MPS_WAKE_CHAR 8'h00
`define MPS_POLICY_RST 2'h0
`define MPS_PIN_IDLE 3'h7

`endif

/* mps_pkg.sv */
/*
  Types shared by the modem power and sleep controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package mps_pkg;

    typedef enum logic [2:0] {
        MPS_OFF,
        MPS_ARM,
        MPS_BOOT,
        MPS_READY,
        MPS_SLEEP,
        MPS_SHUTDOWN
    } mps_state_type;

    typedef enum logic [1:0] {
        MPS_POL_DTR = 2'h0,
        MPS_POL_AUTO = 2'h1,
        MPS_POL_NEVER = 2'h2
    } mps_policy_type;

endpackage

`default_nettype wire

/* mps_pin_sync.sv */
/*
  Three-stage pin synchroniser with agreement filter, one lane per bit.
  Assumes pins are asynchronous to mclk; idle levels given by IDLE.
*/
`default_nettype none

module mps_pin_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output var logic [WIDTH-1:0] pin_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_lane
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic out_ff;
            // only the second and third stages are compared; stage one is never looked at
            wire agree = (s2_ff == s3_ff);
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_ff <= IDLE[gi];
                    s2_ff <= IDLE[gi];
                    s3_ff <= IDLE[gi];
                    out_ff <= IDLE[gi];
                end
                else
                begin
                    s1_ff <= pin_in[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (agree)
                    begin
                        out_ff <= s3_ff;
                    end
                end
            end
            assign pin_out[gi] = out_ff;
        end
    endgenerate

endmodule

`default_nettype wire

/* mps_host_model.sv */
/*
  host board controller model: drives the power request, emergency and dtr pins.
  assumes mclk from the bench; pulse widths are counted in whole mclk periods.
*/
`default_nettype none

module mps_host_model (
    input wire logic mclk,
    input wire logic cts_n,
    output logic power_on_request_n,
    output logic emergency_reset_n,
    output logic dtr_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        power_on_request_n = 1'b1;
        emergency_reset_n = 1'b1;
        dtr_n = 1'b1;
    end

    // released pin floats up to its pull-up, so high is the only idle value
    task automatic power_pulse(input int cyc);
        power_on_request_n <= 1'b0;
        repeat (cyc) @(posedge mclk);
        power_on_request_n <= 1'b1;
    endtask

    // meant only for a device that is not answering commands
    task automatic emergency_pulse(input int cyc);
        power_on_request_n <= 1'b1;
        emergency_reset_n <= 1'b0;
        repeat (cyc) @(posedge mclk);
        emergency_reset_n <= 1'b1;
    endtask

    task automatic set_dtr(input logic active);
        dtr_n <= !active;
    endtask

    // commands go out only after cts has fallen; bounded so a dead device cannot hang us
    task automatic wait_ready(input int lim);
        for (int i = 0; i < lim && cts_n !== 1'b0; i++) @(posedge mclk);
    endtask
endmodule

`default_nettype wire

/* testbench.sv */
/*
  self-checking bench for the modem power and sleep controller.
  assumes the host model drives the pins; long counts are shortened by parameter.
*/
`default_nettype none

module testbench
    import mps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PON = 20;
    localparam int BOOT = 200;
    localparam int EMG = 16;
    localparam int SLP = 10;
    logic mclk = 1'b0;
    logic rst_n, rx_valid, tasks_idle, usb_enum_done, off_cmd, pol_cmd;
    logic [7:0] rx_data;
    logic [1:0] pol_val;
    logic [31:0] rng = 32'h5bc5;
    logic [31:0] tmp;
    wire logic pwr_n, emg_n, dtr_n, io_rail_indicator, cts_n, usb_comm_en, sleep_active, cpu_hold_reset, mem_clear;
    int err_total, check_count, cyc, t0, rise_at, fall_at, mc_cnt, exp_on, exp_rdy, exp_slp;

    mps_host_model mps_host_model_i (.mclk(mclk), .cts_n(cts_n), .power_on_request_n(pwr_n),
        .emergency_reset_n(emg_n), .dtr_n(dtr_n));

    mps_power_ctrl #(.PWR_ON_CYC(PON), .BOOT_CYC(BOOT), .EMG_CYC(EMG), .SLEEP_CYC(SLP)) mps_power_ctrl_i (
        .mclk(mclk), .rst_n(rst_n), .power_on_request_n(pwr_n), .emergency_reset_n(emg_n), .dtr_n(dtr_n),
        .rx_valid(rx_valid), .rx_data(rx_data), .tasks_idle(tasks_idle), .usb_enum_done(usb_enum_done),
        .orderly_poweroff_command(off_cmd), .sleep_policy_command(pol_cmd), .sleep_policy_value(pol_val),
        .io_rail_indicator(io_rail_indicator), .cts_n(cts_n), .usb_comm_en(usb_comm_en),
        .sleep_active(sleep_active), .cpu_hold_reset(cpu_hold_reset), .mem_clear(mem_clear));

    initial
    begin
        forever #4 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic give_verdict();
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // compares every output except mem_clear against the state the reference model expects
    task automatic chk_model();
        chk(io_rail_indicator, exp_on);
        chk(cts_n, 32'(exp_rdy == 0));
        chk(sleep_active, exp_slp);
        chk(cpu_hold_reset, 32'(exp_on == 0));
        chk(usb_comm_en, 32'(exp_rdy != 0 && usb_enum_done === 1'b1));
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic set_policy(input logic [1:0] v);
        pol_val <= v;
        pol_cmd <= 1'b1;
        step(1);
        pol_cmd <= 1'b0;
        step(1);
    endtask

    task automatic send_byte(input logic [7:0] b);
        rx_data <= b;
        rx_valid <= 1'b1;
        step(1);
        rx_valid <= 1'b0;
    endtask

    // request held a little past the minimum, then released while the device boots
    task automatic power_up();
        rise_at = -1;
        fall_at = -1;
        t0 = cyc;
        mps_host_model_i.power_pulse(PON + 6);
        mps_host_model_i.wait_ready(BOOT + 20);
        step(1);
        chk(32'((rise_at - t0) inside {[PON:PON + 8]}), 1);
        chk(32'((fall_at - t0) inside {[BOOT:BOOT + 8]}), 1);
        exp_on = 1;
        exp_rdy = 1;
        chk_model();
    endtask

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (io_rail_indicator === 1'b1 && rise_at < 0)
            rise_at <= cyc;
        if (cts_n === 1'b0 && fall_at < 0)
            fall_at <= cyc;
        if (mem_clear === 1'b1)
            mc_cnt <= mc_cnt + 1;
        if (cyc == 5000)
        begin
            err_total++;
            give_verdict();
        end
    end

    initial
    begin
        {rst_n, rx_valid, tasks_idle, usb_enum_done, off_cmd, pol_cmd} = 6'h00;
        rx_data = 8'h00;
        pol_val = 2'h0;
        step(10);
        rst_n <= 1'b1;
        step(1);
        chk_model();
        chk(mem_clear, 0);
        mps_host_model_i.power_pulse(2 + rnd() % (PON - 8));
        step(PON + 10);
        chk_model();
        mps_host_model_i.set_dtr(1'b1);
        power_up();
        step(2 * SLP);
        chk_model();
        mps_host_model_i.set_dtr(1'b0);
        step(4);
        chk_model();
        step(SLP + 4);
        exp_slp = 1;
        exp_rdy = 0;
        chk_model();
        mps_host_model_i.set_dtr(1'b1);
        step(7);
        exp_slp = 0;
        exp_rdy = 1;
        chk_model();
        usb_enum_done <= 1'b1;
        step(2);
        chk_model();
        set_policy(MPS_POL_AUTO);
        tasks_idle <= 1'b1;
        step(SLP + 3);
        exp_slp = 1;
        exp_rdy = 0;
        chk_model();
        tmp = rnd();
        send_byte(tmp[7:0] | 8'h01);
        step(2);
        chk_model();
        send_byte(8'h00);
        step(1);
        exp_slp = 0;
        exp_rdy = 1;
        chk_model();
        // code 3 must be refused: if it were taken, the idle device would stay awake
        set_policy(2'h3);
        step(SLP + 3);
        exp_slp = 1;
        exp_rdy = 0;
        chk_model();
        // never-sleep set while asleep wakes the device one edge after the policy lands
        set_policy(MPS_POL_NEVER);
        step(1);
        exp_slp = 0;
        exp_rdy = 1;
        chk_model();
        mps_host_model_i.set_dtr(1'b0);
        step(3 * SLP);
        chk_model();
        mps_host_model_i.emergency_pulse(2 + rnd() % (EMG - 8));
        step(6);
        chk_model();
        off_cmd <= 1'b1;
        step(1);
        off_cmd <= 1'b0;
        step(3);
        exp_rdy = 0;
        chk_model();
        step(990);
        chk_model();
        step(14);
        exp_on = 0;
        chk_model();
        power_up();
        mc_cnt = 0;
        mps_host_model_i.emergency_pulse(EMG + 6);
        step(4);
        exp_on = 0;
        exp_rdy = 0;
        chk_model();
        chk(mc_cnt, 1);
        give_verdict();
    end
endmodule

`default_nettype wire
